// File: inc/dpc_defs.svh
`ifndef DPC_DEFS_SVH
`define DPC_DEFS_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define DPC_IDX_A_DATA 8'h06
`define DPC_IDX_C_DATA 8'h07
`define DPC_IDX_CTRL 8'h0b
`define DPC_IDX_OPTION 8'h81
`define DPC_IDX_A_DIR 8'h86
`define DPC_IDX_C_DIR 8'h87

// ****************************************************************
// Field positions
// ****************************************************************
`define DPC_OPT_PULL_BIT 7
`define DPC_OPT_EDGE_BIT 6
`define DPC_CTRL_CHG_BIT 0
`define DPC_CTRL_EXT_BIT 1
`define DPC_EXT_PIN 0
`define DPC_PROG_CLK_PIN 6
`define DPC_PROG_DAT_PIN 7

// ****************************************************************
// Reset values
// ****************************************************************
`define DPC_RST_OPTION 8'hff
`define DPC_RST_DIR 8'hff
`define DPC_RST_LATCH 8'h00
`define DPC_RST_ZERO 8'h00

`endif

// File: inc/dpc_pkg.sv
package dpc_pkg;

  // ****************************************************************
  // State of the port block
  // ****************************************************************
  typedef struct packed {
    logic [7:0] a_sync1;
    logic [7:0] a_sync2;
    logic [7:0] c_sync1;
    logic [7:0] c_sync2;
    logic [7:0] a_latch;
    logic [7:0] c_latch;
    logic [7:0] a_dir;
    logic [7:0] c_dir;
    logic [7:0] option;
    logic ext_prev;
    logic ext_flag;
    logic ack;
    logic [7:0] rdat;
    logic wake;
  } dpc_state_t;

  // ****************************************************************
  // State of the change detector
  // ****************************************************************
  typedef struct packed {
    logic [3:0] snap;
    logic flag;
  } dpc_chg_state_t;

endpackage

// File: inc/dpc_chg_if.sv
`timescale 1ns/1ns

// ****************************************************************
// Link between port control and change detector
// ****************************************************************
interface dpc_chg_if;
  logic [3:0] pins_hi;
  logic [3:0] dir_hi;
  logic refresh;
  logic clr_wr;
  logic clr_val;
  logic ce;
  logic flag;
  logic mismatch;

  modport ctrl (
    output pins_hi, dir_hi, refresh, clr_wr, clr_val, ce,
    input flag, mismatch
  );
  modport det (
    input pins_hi, dir_hi, refresh, clr_wr, clr_val, ce,
    output flag, mismatch
  );
endinterface

// File: design/dpc_change_detect.sv
`timescale 1ns/1ns
`include "dpc_defs.svh"

module dpc_change_detect
  import dpc_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control side
  dpc_chg_if.det chg
);

  dpc_chg_state_t s;
  dpc_chg_state_t next_s;

  // Only input pins take part; outputs are masked off
  assign chg.mismatch = |((chg.pins_hi ^ s.snap) & chg.dir_hi);
  assign chg.flag = s.flag;

  // Snapshot refresh on port access, flag set beats clear
  always_comb begin
    next_s = s;
    if (chg.refresh) begin
      next_s.snap = chg.pins_hi;
    end
    if (chg.clr_wr) begin
      next_s.flag = chg.clr_val;
    end
    // A standing mismatch keeps re-setting the flag
    if (chg.mismatch) begin
      next_s.flag = 1'b1;
    end
  end

  // State register, frozen while clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (chg.ce) begin
      s <= next_s;
    end
  end

  flag_follows_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chg.ce && chg.mismatch |=> s.flag)
    else $error("mismatch did not set change flag");

  flag_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $rose(s.flag) |->
      $past(chg.mismatch) || $past(chg.clr_wr && chg.clr_val))
    else $error("change flag rose without cause");

  snap_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    chg.ce && chg.refresh |=> s.snap == $past(chg.pins_hi))
    else $error("snapshot not refreshed on access");

endmodule

// File: design/dpc_port_top.sv
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ns
`include "dpc_defs.svh"

module dpc_port_top
  import dpc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [9:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // First port pins
  input wire logic [7:0] a_pin_i,
  output logic [7:0] a_pin_o,
  output logic [7:0] a_pin_oe_n_o,
  output logic [7:0] pullup_en_o,
  // Programming interface
  input wire logic prog_mode_i,
  input wire logic prog_data_drive_i,
  input wire logic prog_data_out_i,
  output logic prog_clock_pin_o,
  output logic prog_data_pin_o,
  // Second port pins
  input wire logic [7:0] c_pin_i,
  output logic [7:0] c_pin_o,
  output logic [7:0] c_pin_oe_n_o,
  // Peripheral overrides on the second port
  input wire logic [7:0] periph_en_i,
  input wire logic [7:0] periph_drive_i,
  input wire logic [7:0] periph_out_i,
  // Pin levels handed to the peripherals
  output logic osc_out_timer_clock_pin_o,
  output logic osc_in_capture_two_pin_o,
  output logic capture_compare_one_pin_o,
  output logic serial_clock_pin_o,
  output logic serial_data_in_pin_o,
  output logic serial_data_out_pin_o,
  output logic usart_tx_clock_pin_o,
  output logic usart_rx_data_pin_o,
  // Events and power
  input wire logic sleep_i,
  output logic port_change_flag_o,
  output logic ext_irq_flag_o,
  output logic wake_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  dpc_state_t s;
  dpc_state_t next_s;
  dpc_chg_if chg ();
  logic hit;
  logic [7:0] idx;
  logic ext_evt;
  logic [7:0] wmask;

  localparam dpc_state_t RESET_STATE = '{
    a_sync1: `DPC_RST_ZERO,
    a_sync2: `DPC_RST_ZERO,
    c_sync1: `DPC_RST_ZERO,
    c_sync2: `DPC_RST_ZERO,
    a_latch: `DPC_RST_LATCH,
    c_latch: `DPC_RST_LATCH,
    a_dir: `DPC_RST_DIR,
    c_dir: `DPC_RST_DIR,
    option: `DPC_RST_OPTION,
    ext_prev: 1'b0,
    ext_flag: 1'b0,
    ack: 1'b0,
    rdat: `DPC_RST_ZERO,
    wake: 1'b0
  };

  // ****************************************************************
  // Bus decode
  // ****************************************************************

  // New request only when no ack is out, so each cycle acks once
  assign hit = cyc_i && stb_i && !s.ack;
  assign idx = adr_i[9:2];
  assign wmask = {8{sel_i[0]}};

  // External interrupt edge, chosen by the option register
  assign ext_evt = s.option[`DPC_OPT_EDGE_BIT] ?
                   (s.a_sync2[`DPC_EXT_PIN] && !s.ext_prev) :
                   (!s.a_sync2[`DPC_EXT_PIN] && s.ext_prev);

  // ****************************************************************
  // Change detector hookup
  // ****************************************************************
  assign chg.pins_hi = s.a_sync2[7:4];
  assign chg.dir_hi = s.a_dir[7:4];
  assign chg.refresh = hit && (idx == `DPC_IDX_A_DATA);
  assign chg.clr_wr = hit && we_i && sel_i[0] && (idx == `DPC_IDX_CTRL);
  assign chg.clr_val = dat_i[`DPC_CTRL_CHG_BIT];
  assign chg.ce = ce_i;

  dpc_change_detect u_chg (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .chg(chg)
  );

  // ****************************************************************
  // Next-state logic
  // ****************************************************************

  // Pins, registers, flags and read data in one place
  always_comb begin
    next_s = s;
    next_s.ack = hit;
    // Two flops per pin; the first stage feeds only the second
    next_s.a_sync1 = a_pin_i;
    next_s.a_sync2 = s.a_sync1;
    next_s.c_sync1 = c_pin_i;
    next_s.c_sync2 = s.c_sync1;
    next_s.ext_prev = s.a_sync2[`DPC_EXT_PIN];
    // Register writes
    if (hit && we_i) begin
      case (idx)
        // Pins read, lane merged, result stored in the latch
        `DPC_IDX_A_DATA: begin
          next_s.a_latch = (s.a_sync2 & ~wmask) |
                           (dat_i[7:0] & wmask);
        end
        `DPC_IDX_C_DATA: begin
          next_s.c_latch = (s.c_sync2 & ~wmask) |
                           (dat_i[7:0] & wmask);
        end
        `DPC_IDX_OPTION: begin
          if (sel_i[0]) begin
            next_s.option = dat_i[7:0];
          end
        end
        `DPC_IDX_A_DIR: begin
          if (sel_i[0]) begin
            next_s.a_dir = dat_i[7:0];
          end
        end
        `DPC_IDX_C_DIR: begin
          if (sel_i[0]) begin
            next_s.c_dir = dat_i[7:0];
          end
        end
        `DPC_IDX_CTRL: begin
          if (sel_i[0]) begin
            next_s.ext_flag = dat_i[`DPC_CTRL_EXT_BIT];
          end
        end
        default: begin
          next_s.ext_flag = s.ext_flag;
        end
      endcase
    end
    // Set beats a same-cycle software clear
    if (ext_evt) begin
      next_s.ext_flag = 1'b1;
    end
    // Read data; unmapped words and upper bits read zero
    next_s.rdat = `DPC_RST_ZERO;
    if (hit && !we_i) begin
      case (idx)
        `DPC_IDX_A_DATA: next_s.rdat = s.a_sync2;
        `DPC_IDX_C_DATA: next_s.rdat = s.c_sync2;
        `DPC_IDX_OPTION: next_s.rdat = s.option;
        `DPC_IDX_A_DIR: next_s.rdat = s.a_dir;
        `DPC_IDX_C_DIR: next_s.rdat = s.c_dir;
        `DPC_IDX_CTRL: begin
          next_s.rdat = {6'h00, s.ext_flag, chg.flag};
        end
        default: next_s.rdat = `DPC_RST_ZERO;
      endcase
    end
    // Wake request while asleep and a change is pending
    next_s.wake = sleep_i && (chg.flag || chg.mismatch);
  end

  // State register; reset sets directions to input, pull-ups off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RESET_STATE;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  // ****************************************************************
  // Bus outputs
  // ****************************************************************
  assign ack_o = s.ack;
  assign dat_o = {24'h00_0000, s.rdat};

  // ****************************************************************
  // First port pins
  // ****************************************************************

  // Direction bit high floats the driver; low drives the latch
  always_comb begin
    a_pin_o = s.a_latch;
    a_pin_oe_n_o = s.a_dir;
    // Programming mode takes over the data pin
    if (prog_mode_i) begin
      a_pin_o[`DPC_PROG_DAT_PIN] = prog_data_out_i;
      a_pin_oe_n_o[`DPC_PROG_DAT_PIN] = !prog_data_drive_i;
    end
  end

  // Global enable, but never on a pin that drives
  assign pullup_en_o = {8{!s.option[`DPC_OPT_PULL_BIT]}} &
                       a_pin_oe_n_o;
  assign prog_clock_pin_o = s.a_sync2[`DPC_PROG_CLK_PIN];
  assign prog_data_pin_o = s.a_sync2[`DPC_PROG_DAT_PIN];

  // ****************************************************************
  // Second port pins
  // ****************************************************************

  // Per-pin override; software direction bit is kept but ignored
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_cpin
      assign c_pin_o[gi] = periph_en_i[gi] ? periph_out_i[gi] :
                           s.c_latch[gi];
      assign c_pin_oe_n_o[gi] = periph_en_i[gi] ? !periph_drive_i[gi] :
                                s.c_dir[gi];
    end
  endgenerate

  // Synchronised levels for the sharing peripherals
  assign osc_out_timer_clock_pin_o = s.c_sync2[0];
  assign osc_in_capture_two_pin_o = s.c_sync2[1];
  assign capture_compare_one_pin_o = s.c_sync2[2];
  assign serial_clock_pin_o = s.c_sync2[3];
  assign serial_data_in_pin_o = s.c_sync2[4];
  assign serial_data_out_pin_o = s.c_sync2[5];
  assign usart_tx_clock_pin_o = s.c_sync2[6];
  assign usart_rx_data_pin_o = s.c_sync2[7];

  // ****************************************************************
  // Event outputs
  // ****************************************************************
  assign port_change_flag_o = chg.flag;
  assign ext_irq_flag_o = s.ext_flag;
  assign wake_o = s.wake;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  dir_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hit && we_i && sel_i[0] && idx == `DPC_IDX_A_DIR
      && !prog_mode_i
    |=> a_pin_oe_n_o == $past(dat_i[7:0]))
    else $error("direction write not seen at pin enables");

  latch_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hit && we_i && idx == `DPC_IDX_A_DATA
    |=> s.a_latch == (($past(s.a_sync2) & ~$past(wmask)) |
                      ($past(dat_i[7:0]) & $past(wmask))))
    else $error("data latch merge wrong");

  pull_output_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (pullup_en_o & ~s.a_dir) == 8'h00)
    else $error("pull-up on while driving");

  pull_global_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !s.option[`DPC_OPT_PULL_BIT] && !prog_mode_i
    |-> pullup_en_o == s.a_dir)
    else $error("pull-ups not following enable");

  pull_reset_a: assert property (@(posedge clk_i)
    $past(rst_i) |-> pullup_en_o == 8'h00)
    else $error("pull-ups on after reset");

  ext_edge_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && s.option[`DPC_OPT_EDGE_BIT] && !s.ext_prev
      && s.a_sync2[`DPC_EXT_PIN] |=> s.ext_flag)
    else $error("rising edge missed");

  sync_delay_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i ##1 ce_i |=> s.a_sync2 == $past(a_pin_i, 2))
    else $error("synchroniser depth wrong");

  pin_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hit && !we_i && idx == `DPC_IDX_A_DATA
    |=> ack_o && dat_o[7:0] == $past(s.a_sync2))
    else $error("port read not pin level");

  override_a: assert property (@(posedge clk_i) disable iff (rst_i)
    periph_en_i[3] |-> c_pin_oe_n_o[3] == !periph_drive_i[3]
      && (!periph_drive_i[3] || c_pin_o[3] == periph_out_i[3]))
    else $error("peripheral override ignored");

  wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && sleep_i && chg.mismatch |=> wake_o)
    else $error("no wake on port change");

  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o && ce_i |=> !ack_o)
    else $error("ack held over two cycles");

  ack_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && hit |=> ack_o)
    else $error("bus request not acknowledged");

  ce_freeze_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !ce_i |=> s == $past(s))
    else $error("state moved while clock enable low");

  wake_cause_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(wake_o) |-> $past(sleep_i))
    else $error("wake raised while awake");

endmodule

// File: testbench/dpc_pin_model.sv
`timescale 1ns/1ns

// ****************************************************************
// Board around both ports: keypad or peripheral drivers
// ****************************************************************
module dpc_pin_model (
  // Clock
  input wire logic clk_i,
  // First port as the device drives it
  input wire logic [7:0] a_out_i,
  input wire logic [7:0] a_oe_n_i,
  input wire logic [7:0] pullup_en_i,
  // Second port as the device drives it
  input wire logic [7:0] c_out_i,
  input wire logic [7:0] c_oe_n_i,
  // Outside drivers
  input wire logic [7:0] ext_a_en_i,
  input wire logic [7:0] ext_a_val_i,
  input wire logic [7:0] ext_c_en_i,
  input wire logic [7:0] ext_c_val_i,
  // Resolved wire levels
  output logic [7:0] a_wire_o,
  output logic [7:0] c_wire_o
);
  logic tog;

  // Undriven lines wobble so a stale value never passes as real
  initial tog = 1'b0;
  always @(posedge clk_i) begin
    tog <= ~tog;
  end

  // Device driver wins, then outside driver, then pull-up
  assign a_wire_o = (~a_oe_n_i & a_out_i)
    | (a_oe_n_i & ext_a_en_i & ext_a_val_i)
    | (a_oe_n_i & ~ext_a_en_i & (pullup_en_i | {8{tog}}));
  // Second port has no pull-ups at all
  assign c_wire_o = (~c_oe_n_i & c_out_i)
    | (c_oe_n_i & ext_c_en_i & ext_c_val_i)
    | (c_oe_n_i & ~ext_c_en_i & {8{tog}});
endmodule

// File: testbench/test_dpc_port_top.sv
`timescale 1ns/1ns

module test_dpc_port_top;
  logic clk_i, rst_i, cyc, stb, we, ack_o, ce_i, sleep_i;
  logic [9:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, dat_o;
  logic [7:0] a_pin, a_out, a_oe_n, pull, c_pin, c_out, c_oe_n;
  logic [7:0] ext_a_en, ext_a_val, ext_c_en, ext_c_val;
  logic [7:0] p_en, p_drv, p_out, rd;
  logic [7:0] c_view;
  logic prog_mode, prog_drv, prog_out, prog_clk, prog_dat;
  logic port_change_flag_o, ext_irq_flag_o, wake_o;
  int err_total, total_checks;

  // ****************************************************************
  // Design and board
  // ****************************************************************
  dpc_port_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
    .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .a_pin_i(a_pin),
    .a_pin_o(a_out), .a_pin_oe_n_o(a_oe_n), .pullup_en_o(pull),
    .prog_mode_i(prog_mode), .prog_data_drive_i(prog_drv),
    .prog_data_out_i(prog_out), .prog_clock_pin_o(prog_clk),
    .prog_data_pin_o(prog_dat), .c_pin_i(c_pin), .c_pin_o(c_out),
    .c_pin_oe_n_o(c_oe_n), .periph_en_i(p_en), .periph_drive_i(p_drv),
    .periph_out_i(p_out), .osc_out_timer_clock_pin_o(c_view[0]),
    .osc_in_capture_two_pin_o(c_view[1]),
    .capture_compare_one_pin_o(c_view[2]),
    .serial_clock_pin_o(c_view[3]), .serial_data_in_pin_o(c_view[4]),
    .serial_data_out_pin_o(c_view[5]), .usart_tx_clock_pin_o(c_view[6]),
    .usart_rx_data_pin_o(c_view[7]), .sleep_i(sleep_i),
    .port_change_flag_o(port_change_flag_o),
    .ext_irq_flag_o(ext_irq_flag_o), .wake_o(wake_o));
  dpc_pin_model board (.clk_i(clk_i), .a_out_i(a_out), .a_oe_n_i(a_oe_n),
    .pullup_en_i(pull), .c_out_i(c_out), .c_oe_n_i(c_oe_n),
    .ext_a_en_i(ext_a_en), .ext_a_val_i(ext_a_val), .ext_c_en_i(ext_c_en),
    .ext_c_val_i(ext_c_val), .a_wire_o(a_pin), .c_wire_o(c_pin));

  // ****************************************************************
  // Clock, verdict and helpers
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task cmp(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled high
  task wb(input logic w, input logic [7:0] idx, input logic [7:0] d,
          input logic s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h00_0000, d};
    sel <= {3'h0, s};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    rd = dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack_o !== 1'b1) begin
      cmp("ack", 8'h01, 8'h00);
      complete_run();
    end
  endtask

  task rd_cmp(input string nm, input logic [7:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 1'b1);
    cmp(nm, e, rd);
  endtask

  // Let pins cross the synchroniser, then look between edges
  task settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Bounded wait for a flag or wake, a miss ends the run
  task wait_high(input string nm, input int k);
    logic v;
    int n;
    n = 0;
    v = 1'b0;
    while (v !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      n++;
      case (k)
        0: v = port_change_flag_o;
        1: v = ext_irq_flag_o;
        default: v = wake_o;
      endcase
    end
    cmp(nm, 8'h01, {7'h00, v});
    if (v !== 1'b1) complete_run();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_total = 0;
    total_checks = 0;
    rst_i = 1'b1;
    ce_i = 1'b1;
    {cyc, stb, we, prog_mode, prog_drv, prog_out, sleep_i} = 7'h00;
    adr = 10'h000;
    sel = 4'h0;
    dat = 32'h0000_0000;
    {p_en, p_drv, p_out} = 24'h00_0000;
    {ext_a_en, ext_a_val, ext_c_en, ext_c_val} = 32'hff00_ff00;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values and an unmapped place
    rd_cmp("option", 8'h81, 8'hff);
    rd_cmp("a_dir", 8'h86, 8'hff);
    rd_cmp("c_dir", 8'h87, 8'hff);
    rd_cmp("unmapped", 8'h40, 8'h00);
    settle(0);
    cmp("pullup", 8'h00, pull);
    cmp("a_oe_n", 8'hff, a_oe_n);
    // Pull-ups on, then off on outputs
    wb(1'b1, 8'h81, 8'h7f, 1'b1);
    settle(1);
    cmp("pullup", 8'hff, pull);
    wb(1'b1, 8'h86, 8'hf0, 1'b1);
    wb(1'b1, 8'h06, 8'h5a, 1'b1);
    settle(0);
    cmp("pullup", 8'hf0, pull);
    cmp("a_out", 8'h5a, a_out);
    @(posedge clk_i);
    ext_a_val <= 8'h30;
    settle(3);
    rd_cmp("a_data", 8'h06, 8'h3a);
    wb(1'b1, 8'h06, 8'hff, 1'b0);
    settle(0);
    cmp("a_out", 8'h3a, a_out);
    // Lower pins never flag a change
    wb(1'b1, 8'h86, 8'hff, 1'b1);
    rd_cmp("a_data", 8'h06, 8'h30);
    // Earlier upper-pin change left the flag set; end it before the test
    wb(1'b1, 8'h0b, 8'h00, 1'b1);
    @(posedge clk_i);
    ext_a_val <= 8'h3e;
    settle(6);
    cmp("chg_flag", 8'h00, {7'h00, port_change_flag_o});
    @(posedge clk_i);
    ext_a_val <= 8'h7f;
    wait_high("chg_flag", 0);
    wait_high("ext_flag", 1);
    sleep_i <= 1'b1;
    wait_high("wake", 2);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    // Clear fails while mismatch holds, then access and clear
    wb(1'b1, 8'h0b, 8'h00, 1'b1);
    rd_cmp("ctrl", 8'h0b, 8'h01);
    rd_cmp("a_data", 8'h06, 8'h7f);
    wb(1'b1, 8'h0b, 8'h00, 1'b1);
    rd_cmp("ctrl", 8'h0b, 8'h00);
    // Falling edge selected on the interrupt pin
    wb(1'b1, 8'h81, 8'h3f, 1'b1);
    @(posedge clk_i);
    ext_a_val <= 8'h7e;
    wait_high("ext_flag", 1);
    rd_cmp("ctrl", 8'h0b, 8'h02);
    // Programming lines follow pins 6 and 7
    settle(0);
    cmp("prog", 8'h01, {6'h00, prog_dat, prog_clk});
    @(posedge clk_i);
    {prog_mode, prog_drv, prog_out} <= 3'h7;
    settle(2);
    cmp("prog_drive", 8'h02, {6'h00, a_out[7], a_oe_n[7]});
    // Second port: plain writes only, no bit read-modify-write
    wb(1'b1, 8'h87, 8'h0f, 1'b1);
    wb(1'b1, 8'h07, 8'ha5, 1'b1);
    settle(3);
    cmp("c_oe_n", 8'h0f, c_oe_n);
    rd_cmp("c_data", 8'h07, 8'ha0);
    @(posedge clk_i);
    {p_en, p_drv, p_out} <= 24'h0f_050c;
    settle(0);
    cmp("c_oe_n", 8'h0a, c_oe_n);
    cmp("c_out", 8'hac, c_out);
    @(posedge clk_i);
    p_en <= 8'h00;
    ext_c_val <= 8'h96;
    wb(1'b1, 8'h87, 8'hff, 1'b1);
    settle(3);
    cmp("c_view", 8'h96, c_view);
    // Enable low freezes the synchronisers, so the views hold
    @(posedge clk_i);
    ce_i <= 1'b0;
    ext_c_val <= 8'h69;
    settle(3);
    cmp("c_frozen", 8'h96, c_view);
    @(posedge clk_i);
    ce_i <= 1'b1;
    settle(3);
    cmp("c_view", 8'h69, c_view);
    complete_run();
  end
endmodule
